//--- common/afs_cfg.svh
/*
 * Constants of the arithmetic unit and flag register: file indices, APB layout,
 * field positions and reset values.
 * Assumes it is included by bare name after the package is compiled.
 */
`ifndef AFS_CFG_SVH
`define AFS_CFG_SVH
// file indices; APB byte address is four times the index
`define AFS_IDX_FLAGS  8'h04
`define AFS_IDX_ACC    8'h0A
`define AFS_IDX_MULTIPLY_RESULT_LOW  8'h18
`define AFS_IDX_MULTIPLY_RESULT_HIGH  8'h19
`define AFS_APB_AW     12
// flag register layout
`define AFS_BIT_OV     3
`define AFS_BIT_Z      2
`define AFS_BIT_DC     1
`define AFS_BIT_C      0
`define AFS_MODE_HI    7:4
`define AFS_PTR1_MODE  7:6
`define AFS_PTR0_MODE  5:4
`define AFS_LOW_FLAGS  2:0
// pointer step fields: the high bit of a field means hold, the low bit picks increment
`define AFS_BIT_P1HOLD 7
`define AFS_BIT_P1INC  6
`define AFS_BIT_P0HOLD 5
`define AFS_BIT_P0INC  4
// reset values
`define AFS_FLAG_RST   8'hF0
`define AFS_ACC_RST    8'h00
`endif

//--- common/afs_pkg.sv
/*
 * Types of the arithmetic unit: opcodes, operand source, destination,
 * pointer step modes and the carriers of instruction and file write.
 * Assumes a single core clock shared with the instruction sequencer.
 */
package afs_pkg;
   typedef enum logic [4:0] {
      AFS_OP_ADD, AFS_OP_ADDC, AFS_OP_SUB, AFS_OP_SUBB, AFS_OP_INC, AFS_OP_DEC,
      AFS_OP_AND, AFS_OP_IOR, AFS_OP_XOR, AFS_OP_COM, AFS_OP_MOVF, AFS_OP_CLR,
      AFS_OP_SWAP, AFS_OP_BCLR, AFS_OP_BSET, AFS_OP_MOVACC, AFS_OP_RLC, AFS_OP_RRC,
      AFS_OP_MUL
   } afs_op_t;
   typedef enum logic [1:0] {AFS_SRC_FILE, AFS_SRC_LIT, AFS_SRC_ACC} afs_src_t;
   typedef enum logic {AFS_DST_ACC, AFS_DST_FILE} afs_dst_t;
   typedef enum logic [1:0] {
      AFS_STEP_DEC = 2'h0, AFS_STEP_INC = 2'h1, AFS_STEP_HOLD = 2'h2
   } afs_step_t;
   typedef struct packed {
      afs_op_t    op;
      afs_src_t   src;
      afs_dst_t   dst;
      logic [7:0] fileAddr;
      logic [7:0] literal;
      logic [2:0] bitSel;
   } afs_instr_t;
   typedef struct packed {
      logic       we;
      logic [7:0] addr;
      logic [7:0] data;
   } afs_fwr_t;
endpackage : afs_pkg

//--- hdl/afs_alu_status_flags.sv
/*
 * 8-bit arithmetic unit with flag register, working accumulator and product
 * registers, reachable by the core and over APB.
 * Assumes the sequencer issues one instruction per valid cycle on core_clk and
 * answers file reads combinationally on fileRdData for external addresses.
 */
// Function
// RULE_01 - operations take two operands or one, as the opcode says
// RULE_02 - single-operand operations read the accumulator or a file register
// RULE_03 - two-operand operations use the accumulator plus file register or literal
// RULE_04 - flag register as destination: computed zero, nibble carry, carry win
// RULE_05 - clearing the flag register clears mode bits, sets zero, keeps the rest
// RULE_06 - software should alter flags only with no-flag instructions
// RULE_07 - in subtraction carry and nibble carry mean no borrow when set
// RULE_08 - signed range flag set when signed result leaves -128..+127
// RULE_09 - multiplier writes 16-bit product to low 18h and high 19h
// RULE_10 - product registers absent without multiplier, never reset otherwise
// RULE_11 - pointer mode field: 00 decrement, 01 increment, 1x hold
// RULE_12 - addition sets nibble carry on carry out of bit three
// RULE_13 - zero flag follows an all-zero operation result
// RULE_14 - flag register at file 04h; mode bits and signed flag writable
// RULE_15 - flags update on the same edge that writes the result; results for external files land one edge later through the registered fileWr
`include "afs_cfg.svh"
module afs_alu_status_flags
   import afs_pkg::*;
#(
   parameter bit HAS_MULT = 1'b1
) (
   input  wire logic                   core_clk,
   input  wire logic                   sys_rst,
   input  wire logic                   instrValid,
   input  wire afs_instr_t             instr,
   input  wire logic [7:0]             fileRdData,
   output afs_fwr_t                    fileWr,
   output logic      [7:0]             arithFlags,
   output afs_step_t                   ptr0Step,
   output afs_step_t                   ptr1Step,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [`AFS_APB_AW-1:0] paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr
);
   logic [7:0] acc, multiply_result_low, multiply_result_high;
   logic [7:0] next_flags, next_acc, next_multiply_result_low, next_multiply_result_high;
   logic [7:0] fileVal, opB, res, addX, addY, rdVal;
   logic [8:0] sum9;
   logic [4:0] nib;
   logic       addCin, isArith, isZ, isRot, rotC, noWrite, toFlags, affLow;
   logic       apbWr, rdHit;
   logic [9:0] regIdx;

   assign regIdx = paddr[`AFS_APB_AW-1:2];
   assign apbWr  = psel & penable & pready & pwrite & ~pslverr;

   // file read: internal registers answer themselves, the rest come from outside
   always_comb begin
      unique case (instr.fileAddr)
         `AFS_IDX_FLAGS: fileVal = arithFlags;
         `AFS_IDX_ACC:   fileVal = acc;
         `AFS_IDX_MULTIPLY_RESULT_LOW: fileVal = HAS_MULT ? multiply_result_low : fileRdData;
         `AFS_IDX_MULTIPLY_RESULT_HIGH: fileVal = HAS_MULT ? multiply_result_high : fileRdData;
         default:        fileVal = fileRdData;
      endcase
   end

   // operand path; two-operand ops always pair the accumulator with opB
   always_comb begin
      unique case (instr.src)
         AFS_SRC_FILE: opB = fileVal;            // RULE_02 RULE_03
         AFS_SRC_LIT:  opB = instr.literal;      // RULE_03
         default:      opB = acc;                // RULE_02
      endcase
   end

   // operation decode and result
   always_comb begin
      addX = 8'h00; addY = 8'h00; addCin = 1'b0;
      isArith = 1'b0; isZ = 1'b0; isRot = 1'b0; rotC = 1'b0; noWrite = 1'b0;
      res = opB;
      unique case (instr.op)                    // RULE_01
         AFS_OP_ADD:    begin addX = acc; addY = opB; isArith = 1'b1; end
         AFS_OP_ADDC:   begin addX = acc; addY = opB; addCin = arithFlags[`AFS_BIT_C];
                              isArith = 1'b1; end
         // subtract by adding the complement: carry out set means no borrow
         AFS_OP_SUB:    begin addX = opB; addY = ~acc; addCin = 1'b1; isArith = 1'b1; end // RULE_07
         AFS_OP_SUBB:   begin addX = opB; addY = ~acc; addCin = arithFlags[`AFS_BIT_C];
                              isArith = 1'b1; end // RULE_07
         AFS_OP_INC:    begin addX = opB; addCin = 1'b1; isArith = 1'b1; end
         AFS_OP_DEC:    begin addX = opB; addY = 8'hFF; isArith = 1'b1; end
         AFS_OP_AND:    begin res = acc & opB; isZ = 1'b1; end
         AFS_OP_IOR:    begin res = acc | opB; isZ = 1'b1; end
         AFS_OP_XOR:    begin res = acc ^ opB; isZ = 1'b1; end
         AFS_OP_COM:    begin res = ~opB; isZ = 1'b1; end
         AFS_OP_MOVF:   isZ = 1'b1;
         AFS_OP_CLR:    begin res = 8'h00; isZ = 1'b1; end
         AFS_OP_SWAP:   res = {opB[3:0], opB[7:4]};
         AFS_OP_BCLR:   res = opB & ~(8'h01 << instr.bitSel);
         AFS_OP_BSET:   res = opB | (8'h01 << instr.bitSel);
         AFS_OP_MOVACC: res = acc;
         AFS_OP_RLC:    begin res = {opB[6:0], arithFlags[`AFS_BIT_C]}; rotC = opB[7];
                              isRot = 1'b1; end
         AFS_OP_RRC:    begin res = {arithFlags[`AFS_BIT_C], opB[7:1]}; rotC = opB[0];
                              isRot = 1'b1; end
         default:       noWrite = 1'b1;          // multiply only loads the product
      endcase
      nib  = {1'b0, addX[3:0]} + {1'b0, addY[3:0]} + {4'h0, addCin};
      sum9 = {1'b0, addX} + {1'b0, addY} + {8'h00, addCin};
      if (isArith) res = sum9[7:0];
   end

   assign toFlags = instrValid & ~noWrite & (instr.dst == AFS_DST_FILE)
                    & (instr.fileAddr == `AFS_IDX_FLAGS);
   assign affLow  = isArith | isZ | isRot;

   // flag register: APB write first, then the instruction, computed flags last
   always_comb begin
      next_flags = arithFlags;
      if (apbWr && regIdx == {2'b00, `AFS_IDX_FLAGS}) next_flags = pwdata[7:0];  // RULE_14
      if (toFlags) begin
         next_flags[`AFS_MODE_HI] = res[`AFS_MODE_HI];                            // RULE_05 RULE_14
         // hardware-owned bits keep their computed value, the write is dropped
         if (!affLow) next_flags[`AFS_BIT_OV:0] = res[`AFS_BIT_OV:0];             // RULE_04 RULE_05
      end
      if (instrValid && isArith) begin                                           // RULE_15
         next_flags[`AFS_BIT_OV] = (addX[7] == addY[7]) && (sum9[7] != addX[7]); // RULE_08
         next_flags[`AFS_BIT_DC] = nib[4];                                       // RULE_12 RULE_07
         next_flags[`AFS_BIT_C]  = sum9[8];                                      // RULE_07
      end
      if (instrValid && (isArith || isZ)) next_flags[`AFS_BIT_Z] = (res == 8'h00); // RULE_13
      if (instrValid && isRot) next_flags[`AFS_BIT_C] = rotC;
   end

   // accumulator: written as destination or as file 0Ah
   always_comb begin
      next_acc = acc;
      if (apbWr && regIdx == {2'b00, `AFS_IDX_ACC}) next_acc = pwdata[7:0];
      if (instrValid && !noWrite && (instr.dst == AFS_DST_ACC ||
          instr.fileAddr == `AFS_IDX_ACC)) next_acc = res;                        // RULE_15
   end

   // product registers; a multiply overrides any other write in the same cycle
   always_comb begin
      next_multiply_result_low = multiply_result_low;
      next_multiply_result_high = multiply_result_high;
      if (apbWr && regIdx == {2'b00, `AFS_IDX_MULTIPLY_RESULT_LOW}) next_multiply_result_low = pwdata[7:0];
      if (apbWr && regIdx == {2'b00, `AFS_IDX_MULTIPLY_RESULT_HIGH}) next_multiply_result_high = pwdata[7:0];
      if (instrValid && !noWrite && instr.dst == AFS_DST_FILE) begin
         if (instr.fileAddr == `AFS_IDX_MULTIPLY_RESULT_LOW) next_multiply_result_low = res;
         if (instr.fileAddr == `AFS_IDX_MULTIPLY_RESULT_HIGH) next_multiply_result_high = res;
      end
      if (instrValid && instr.op == AFS_OP_MUL) begin                              // RULE_09
         {next_multiply_result_high, next_multiply_result_low} = 16'(acc) * 16'(opB);
      end
   end

   // flags and pointer step decode share the reset
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         arithFlags <= `AFS_FLAG_RST;
         ptr0Step   <= AFS_STEP_HOLD;
         ptr1Step   <= AFS_STEP_HOLD;
      end else begin
         arithFlags <= next_flags;
         ptr0Step   <= next_flags[`AFS_BIT_P0HOLD] ? AFS_STEP_HOLD :
                       (next_flags[`AFS_BIT_P0INC] ? AFS_STEP_INC : AFS_STEP_DEC); // RULE_11
         ptr1Step   <= next_flags[`AFS_BIT_P1HOLD] ? AFS_STEP_HOLD :
                       (next_flags[`AFS_BIT_P1INC] ? AFS_STEP_INC : AFS_STEP_DEC); // RULE_11
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) acc <= `AFS_ACC_RST;
      else         acc <= next_acc;
   end

   // no reset on purpose: contents survive every reset, undefined after power-up
   always_ff @(posedge core_clk) begin
      if (HAS_MULT) begin                                                         // RULE_10
         multiply_result_low <= next_multiply_result_low;
         multiply_result_high <= next_multiply_result_high;
      end else begin
         multiply_result_low <= 8'h00;
         multiply_result_high <= 8'h00;
      end
   end

   // writes to files that live outside this block
   always_ff @(posedge core_clk) begin
      if (sys_rst) fileWr <= '0;
      else begin
         fileWr.we   <= instrValid & ~noWrite & (instr.dst == AFS_DST_FILE) &
                        ~(instr.fileAddr == `AFS_IDX_FLAGS || instr.fileAddr == `AFS_IDX_ACC ||
                          (HAS_MULT && (instr.fileAddr == `AFS_IDX_MULTIPLY_RESULT_LOW ||
                                        instr.fileAddr == `AFS_IDX_MULTIPLY_RESULT_HIGH)));
         fileWr.addr <= instr.fileAddr;
         fileWr.data <= res;
      end
   end

   // APB read decode; product registers are unmapped on the variant without them
   always_comb begin
      rdHit = 1'b1;
      rdVal = 8'h00;
      if (paddr[1:0] != 2'h0) rdHit = 1'b0;
      else unique case (regIdx)
         {2'b00, `AFS_IDX_FLAGS}: rdVal = arithFlags;
         {2'b00, `AFS_IDX_ACC}:   rdVal = acc;
         {2'b00, `AFS_IDX_MULTIPLY_RESULT_LOW}: begin rdVal = HAS_MULT ? multiply_result_low : 8'h00; rdHit = HAS_MULT; end
         {2'b00, `AFS_IDX_MULTIPLY_RESULT_HIGH}: begin rdVal = HAS_MULT ? multiply_result_high : 8'h00; rdHit = HAS_MULT; end
         default:                 rdHit = 1'b0;
      endcase
   end

   // answer is prepared in the setup cycle so every APB output is a flop
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~rdHit;
         prdata  <= (psel & ~penable & ~pwrite) ? {24'h00_0000, rdVal} : 32'h0000_0000;
      end
   end

   // checking helpers
   logic        resZero, ovRange, noBorrow, lastCarry;
   logic signed [9:0] sSum;
   logic [2:0]  keepBits;
   assign resZero   = (res == 8'h00);
   assign sSum      = 10'(signed'(acc)) + 10'(signed'(opB));
   assign ovRange   = (sSum > 10'sh07F) || (sSum < -10'sh080);
   assign noBorrow  = (opB >= acc);
   assign lastCarry = sum9[8];
   assign keepBits  = {arithFlags[`AFS_BIT_OV], arithFlags[`AFS_BIT_DC], arithFlags[`AFS_BIT_C]};

   a_zero_track: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_13
      instrValid && (isArith || isZ) |=> arithFlags[`AFS_BIT_Z] == $past(resZero))
      else $error("zero flag does not follow result");
   a_sub_borrow: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_07
      instrValid && instr.op == AFS_OP_SUB |=> arithFlags[`AFS_BIT_C] == $past(noBorrow))
      else $error("subtract carry is not inverted borrow");
   a_ovf_range: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_08
      instrValid && instr.op == AFS_OP_ADD |=> arithFlags[`AFS_BIT_OV] == $past(ovRange))
      else $error("signed range flag wrong after add");
   a_nibble_carry: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_12
      instrValid && instr.op == AFS_OP_ADD && instr.src == AFS_SRC_LIT
      |=> arithFlags[`AFS_BIT_DC] == ($past(acc[3:0]) + $past(instr.literal[3:0]) > 5'h0F))
      else $error("nibble carry wrong after add");
   a_flag_protect: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_04
      toFlags && isArith |=> arithFlags[`AFS_LOW_FLAGS] ==
         {$past(resZero), $past(nib[4]), $past(lastCarry)})
      else $error("written flag bits overrode computed flags");
   a_clear_flags: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_05
      toFlags && instr.op == AFS_OP_CLR && !apbWr |=> arithFlags[`AFS_MODE_HI] == 4'h0
         && arithFlags[`AFS_BIT_Z] && keepBits == $past(keepBits))
      else $error("clearing flag register gave wrong bits");
   a_step_mode: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_11
      ptr0Step == (arithFlags[`AFS_BIT_P0HOLD] ? AFS_STEP_HOLD :
                   (arithFlags[`AFS_BIT_P0INC] ? AFS_STEP_INC : AFS_STEP_DEC)))
      else $error("pointer step mode mismatch");
   a_mul_product: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_09
      instrValid && instr.op == AFS_OP_MUL && HAS_MULT
      |=> {multiply_result_high, multiply_result_low} == 16'($past(acc)) * 16'($past(opB)))
      else $error("product registers not loaded");
   a_two_operand: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_03
      instrValid && instr.op == AFS_OP_AND && instr.src == AFS_SRC_LIT && instr.dst == AFS_DST_ACC
      |=> acc == ($past(acc) & $past(instr.literal)))
      else $error("two-operand and used wrong operands");
endmodule : afs_alu_status_flags

//--- test/afs_file_model.sv
/*
 * Model of the external file registers that sit behind the sequencer.
 * Assumes reads are answered in the same cycle and writes land on the fileWr pulse.
 */
module afs_file_model
   import afs_pkg::*;
(
   input  wire logic       core_clk,
   input  wire afs_fwr_t   fileWr,
   input  wire logic [7:0] rdAddr,
   output logic      [7:0] rdData
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [256];
   // each location starts at its own address, so expected reads are known
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'(i);
      end
   end
   // writes land only on the edge that carries the one-cycle pulse
   always @(posedge core_clk) begin
      if (fileWr.we === 1'b1) begin
         mem[fileWr.addr] <= fileWr.data;
      end
   end
   // combinational answer; the unit samples it at the instruction edge
   assign rdData = mem[rdAddr];
endmodule : afs_file_model

//--- test/testbench.sv
/*
 * Self-checking bench of the arithmetic unit: reset, table of operations, then
 * pointer modes, flag destination, product and APB refusal cases.
 * Assumes a wait-free APB slave and one instruction per cycle.
 */
module testbench
   import afs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {afs_op_t op; afs_src_t src; logic [7:0] fa, lit, a0, ae, fe, fm;} afs_row_t;
   logic        core_clk, sys_rst, instrValid, psel, penable, pwrite, pready, pslverr;
   afs_instr_t  instr;
   afs_fwr_t    fileWr;
   afs_step_t   ptr0Step, ptr1Step;
   logic [7:0]  fileRdData, arithFlags;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        er;
   int          failCount, comparisons;
   afs_row_t    rows [20];
   afs_alu_status_flags #(.HAS_MULT(1'b1)) i_afs_alu_status_flags (.core_clk(core_clk),
      .sys_rst(sys_rst), .instrValid(instrValid), .instr(instr), .fileRdData(fileRdData),
      .fileWr(fileWr), .arithFlags(arithFlags), .ptr0Step(ptr0Step), .ptr1Step(ptr1Step),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   afs_file_model i_afs_file_model (.core_clk(core_clk), .fileWr(fileWr),
      .rdAddr(instr.fileAddr), .rdData(fileRdData));
   // free-running core clock, 10 ns period
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failCount++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic finishTest();
      if (failCount == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : finishTest
   // one APB transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge core_clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rdChk(input string name, input logic [11:0] a, input logic [7:0] exp);
      apb(1'b0, a, 32'h0);
      check(name, rd, {24'h0, exp});
   endtask : rdChk
   // one instruction, results looked at just after the edge that takes it
   task automatic run(afs_op_t op, afs_src_t src, afs_dst_t dst, logic [7:0] fa, logic [7:0] lit);
      @(posedge core_clk);
      instrValid <= 1'b1;
      instr <= '{op: op, src: src, dst: dst, fileAddr: fa, literal: lit, bitSel: 3'h0};
      @(posedge core_clk);
      instrValid <= 1'b0;
      #1;
   endtask : run
   initial begin
      repeat (5000) @(posedge core_clk);
      failCount++;
      finishTest();
   end
   initial begin
      {sys_rst, instrValid, psel, penable, pwrite} = 5'b10000;
      paddr = 12'h0; pwdata = 32'h0; instr = '0; failCount = 0; comparisons = 0;
      // op, src, file, literal, acc before, acc after, flags, flag mask
      rows = '{'{AFS_OP_ADD, AFS_SRC_LIT, 8'h00, 8'h01, 8'h7F, 8'h80, 8'h0A, 8'h0F},
               '{AFS_OP_ADD, AFS_SRC_LIT, 8'h00, 8'h01, 8'hFF, 8'h00, 8'h07, 8'h0F},
               '{AFS_OP_SUB, AFS_SRC_LIT, 8'h00, 8'h05, 8'h03, 8'h02, 8'h03, 8'h0F},
               '{AFS_OP_SUB, AFS_SRC_LIT, 8'h00, 8'h03, 8'h05, 8'hFE, 8'h00, 8'h0F},
               '{AFS_OP_SUB, AFS_SRC_LIT, 8'h00, 8'h80, 8'h01, 8'h7F, 8'h09, 8'h0F},
               '{AFS_OP_AND, AFS_SRC_LIT, 8'h00, 8'h0F, 8'hF0, 8'h00, 8'h04, 8'hF4},
               '{AFS_OP_IOR, AFS_SRC_LIT, 8'h00, 8'h0F, 8'hF0, 8'hFF, 8'h00, 8'hF4},
               '{AFS_OP_XOR, AFS_SRC_LIT, 8'h00, 8'h5A, 8'h5A, 8'h00, 8'h04, 8'hF4},
               '{AFS_OP_COM, AFS_SRC_ACC, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h04, 8'hF4},
               '{AFS_OP_INC, AFS_SRC_ACC, 8'h00, 8'h00, 8'h7F, 8'h80, 8'h0A, 8'hFF},
               '{AFS_OP_ADD, AFS_SRC_FILE, 8'h30, 8'h00, 8'h10, 8'h40, 8'h00, 8'hFF},
               '{AFS_OP_MOVF, AFS_SRC_FILE, 8'h30, 8'h00, 8'h00, 8'h30, 8'h00, 8'hF4},
               '{AFS_OP_ADDC, AFS_SRC_LIT, 8'h00, 8'h0F, 8'h01, 8'h10, 8'h02, 8'h0F},
               '{AFS_OP_SUBB, AFS_SRC_LIT, 8'h00, 8'h05, 8'h03, 8'h01, 8'h03, 8'h0F},
               '{AFS_OP_DEC, AFS_SRC_ACC, 8'h00, 8'h00, 8'h01, 8'h00, 8'h07, 8'hFF},
               '{AFS_OP_SWAP, AFS_SRC_ACC, 8'h00, 8'h00, 8'hA5, 8'h5A, 8'h00, 8'hFF},
               '{AFS_OP_BCLR, AFS_SRC_ACC, 8'h00, 8'h00, 8'hFF, 8'hFE, 8'h00, 8'hFF},
               '{AFS_OP_BSET, AFS_SRC_ACC, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'hFF},
               '{AFS_OP_RLC, AFS_SRC_ACC, 8'h00, 8'h00, 8'h81, 8'h02, 8'h01, 8'hFF},
               '{AFS_OP_RRC, AFS_SRC_ACC, 8'h00, 8'h00, 8'h81, 8'h40, 8'h01, 8'hFF}};
      repeat (12) @(posedge core_clk);
      sys_rst <= 1'b0;
      rdChk("flags reset", 12'h010, 8'hF0);
      rdChk("acc reset", 12'h028, 8'h00);
      check("ptr0 reset", ptr0Step, AFS_STEP_HOLD);
      // table of operations; flags seen right after the executing edge
      foreach (rows[i]) begin
         apb(1'b1, 12'h028, {24'h0, rows[i].a0});
         apb(1'b1, 12'h010, 32'h0);
         run(rows[i].op, rows[i].src, AFS_DST_ACC, rows[i].fa, rows[i].lit);
         check("flags", arithFlags & rows[i].fm, rows[i].fe & rows[i].fm);
         rdChk("acc", 12'h028, rows[i].ae);
      end
      // every pointer mode code, both fields at once
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, 12'h010, {24'h0, 2'(m), 2'(m), 4'h0});
         @(posedge core_clk);
         #1;
         check("ptr0", ptr0Step, m == 0 ? AFS_STEP_DEC : m == 1 ? AFS_STEP_INC : AFS_STEP_HOLD);
         check("ptr1", ptr1Step, m == 0 ? AFS_STEP_DEC : m == 1 ? AFS_STEP_INC : AFS_STEP_HOLD);
         rdChk("flags rw", 12'h010, {2'(m), 2'(m), 4'h0});
      end
      // flag register as destination: computed low flags beat the result
      apb(1'b1, 12'h010, 32'h0);
      apb(1'b1, 12'h028, 32'h55);
      run(AFS_OP_ADD, AFS_SRC_FILE, AFS_DST_FILE, 8'h04, 8'h00);
      check("flags dest", arithFlags, 8'h50);
      check("no ext write", fileWr.we, 1'b0);
      apb(1'b1, 12'h010, 32'hFB);
      run(AFS_OP_CLR, AFS_SRC_FILE, AFS_DST_FILE, 8'h04, 8'h00);
      check("flags clear", arithFlags, 8'h0F);
      // a move that touches no status bit writes all eight bits
      apb(1'b1, 12'h028, 32'h3C);
      run(AFS_OP_MOVACC, AFS_SRC_ACC, AFS_DST_FILE, 8'h04, 8'h00);
      check("flags move", arithFlags, 8'h3C);
      run(AFS_OP_MOVACC, AFS_SRC_ACC, AFS_DST_FILE, 8'h40, 8'h00);
      check("ext write", {fileWr.we, fileWr.addr, fileWr.data}, {1'b1, 8'h40, 8'h3C});
      apb(1'b1, 12'h028, 32'h0);
      run(AFS_OP_MOVF, AFS_SRC_FILE, AFS_DST_ACC, 8'h40, 8'h00);
      rdChk("acc file", 12'h028, 8'h3C);
      // product registers, then a reset in mid-run must leave the low one alone
      apb(1'b1, 12'h028, 32'h12);
      run(AFS_OP_MUL, AFS_SRC_LIT, AFS_DST_ACC, 8'h00, 8'h34);
      rdChk("prod low", 12'h060, 8'hA8);
      rdChk("prod high", 12'h064, 8'h03);
      rdChk("acc after mul", 12'h028, 8'h12);
      sys_rst <= 1'b1;
      repeat (3) @(posedge core_clk);
      sys_rst <= 1'b0;
      rdChk("prod kept", 12'h060, 8'hA8);
      check("kept err", er, 1'b0);
      rdChk("flags reset2", 12'h010, 8'hF0);
      // unmapped and unaligned accesses are refused with zero data
      rdChk("unmapped", 12'h100, 8'h00);
      check("unmapped err", er, 1'b1);
      rdChk("unaligned", 12'h011, 8'h00);
      check("unaligned err", er, 1'b1);
      // the answer stands for the access phase only
      #1;
      check("pready drop", pready, 1'b0);
      finishTest();
   end
endmodule : testbench
